/* File: mobls_pkg.sv */
package mobls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Burst shape
  localparam int MSGS_PER_BURST = 8;
  localparam logic [2:0] LAST_MSG_IDX = 3'h7;
  localparam logic [2:0] LAST_BURST_IDX = 3'h7;
  // Zero-based burst indices carrying the safety text
  localparam logic [2:0] TEXT_BURST_A = 3'h0;
  localparam logic [2:0] TEXT_BURST_B = 3'h4;
  // Zero-based message positions of the text inside those bursts
  localparam logic [2:0] TEXT_POS_A = 3'h4;
  localparam logic [2:0] TEXT_POS_B = 3'h5;
  // Burst index carrying UTC and the one carrying the increment
  localparam logic [2:0] UTC_BURST = 3'h6;
  localparam logic [2:0] INCR_BURST = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Message field codes
  localparam logic [5:0] MSG_POS_REPORT = 6'h01;
  localparam logic [5:0] MSG_SAFETY_TEXT = 6'h0e;
  localparam logic [3:0] NAV_ACTIVE = 4'he;
  localparam logic [3:0] NAV_TEST = 4'hf;
  localparam logic [2:0] TIME_OUT_FIRST = 3'h7;
  localparam logic [2:0] TIME_OUT_TEST = 3'h0;
  localparam logic [5:0] TIME_STAMP_NA = 6'h3f;
  localparam logic [1:0] SYNC_UTC_DIRECT = 2'h0;
  localparam logic [1:0] SYNC_NO_FIX = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths
  localparam int LON_W = 28;
  localparam int LAT_W = 27;
  localparam int COG_W = 12;
  localparam int SOG_W = 10;
  localparam int SUB_W = 14;
  localparam int CNT_W = 14;
  localparam int INCR_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Defaults when no position is known, 1/10000 minute per unit
  localparam int UNITS_PER_DEG = 600000;
  localparam int LON_NA_DEG = 181;
  localparam int LAT_NA_DEG = 91;
  localparam logic [LON_W-1:0] LON_NA = LON_W'(LON_NA_DEG * UNITS_PER_DEG);
  localparam logic [LAT_W-1:0] LAT_NA = LAT_W'(LAT_NA_DEG * UNITS_PER_DEG);
  localparam logic [COG_W-1:0] COG_NA = 12'he10;
  localparam logic [SOG_W-1:0] SOG_NA = 10'h3ff;

  ////////////////////////////////////////////////////////////////////////////
  // Random slot increment to the burst after the last one
  localparam int INCR_MIN = 2025;
  localparam int INCR_MAX = 2475;
  localparam logic [8:0] INCR_SPAN = 9'(INCR_MAX - INCR_MIN + 1);
  localparam logic [15:0] LFSR_SEED_DEF = 16'hace1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, counted in slot ticks
  localparam int SLOTS_PER_MIN_DEF = 2250;
  localparam int TEST_WAIT_MIN = 5;
  localparam int TEST_WAIT_SLOTS_DEF = TEST_WAIT_MIN * SLOTS_PER_MIN_DEF;

  typedef enum logic [1:0] {SUB_ZERO, SUB_SLOT, SUB_UTC, SUB_INCR} mobls_sub_e;

endpackage

/* File: mobls_rand_incr.sv */
`timescale 1ns/1ps
module mobls_rand_incr
  import mobls_pkg::*;
#(
  parameter logic [15:0] SEED = LFSR_SEED_DEF
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic [INCR_W-1:0] incr
);

  logic [15:0] lfsr_r;
  logic [15:0] lfsr_nxt;
  logic [INCR_W-1:0] incr_r;
  logic [INCR_W-1:0] incr_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running LFSR; rejection keeps the draw uniform over the span
  always_comb begin
    lfsr_nxt = {lfsr_r[14:0],
                lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    incr_nxt = incr_r;
    if (lfsr_r[8:0] < INCR_SPAN) begin
      incr_nxt = INCR_W'(INCR_MIN) + INCR_W'(lfsr_r[8:0]);
    end
  end

  // Seed must be nonzero or the LFSR locks up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_r <= SEED;
      incr_r <= INCR_W'(INCR_MIN);
    end else if (clk_en) begin
      lfsr_r <= lfsr_nxt;
      incr_r <= incr_nxt;
    end
  end

  assign incr = incr_r;

endmodule

/* File: mobls_fix_hold.sv */
`timescale 1ns/1ps
module mobls_fix_hold
  import mobls_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic fix_valid,
  input wire logic [LON_W-1:0] gnss_lon,
  input wire logic [LAT_W-1:0] gnss_lat,
  input wire logic [COG_W-1:0] gnss_course_over_ground_field,
  input wire logic [SOG_W-1:0] gnss_speed_over_ground_field,
  input wire logic [5:0] utc_second,
  output logic [LON_W-1:0] pos_lon,
  output logic [LAT_W-1:0] pos_lat,
  output logic [COG_W-1:0] pos_course_over_ground_field,
  output logic [SOG_W-1:0] pos_speed_over_ground_field,
  output logic [5:0] pos_time_stamp,
  output logic [1:0] pos_sync_state
);

  logic had_fix_r, had_fix_nxt;
  logic [LON_W-1:0] lon_r, lon_nxt;
  logic [LAT_W-1:0] lat_r, lat_nxt;
  logic [COG_W-1:0] cog_r, cog_nxt;
  logic [SOG_W-1:0] sog_r, sog_nxt;
  logic [5:0] ts_r, ts_nxt;
  logic [1:0] sync_r, sync_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Live fix, else last known, else defaults
  always_comb begin
    had_fix_nxt = had_fix_r;
    lon_nxt = lon_r;
    lat_nxt = lat_r;
    cog_nxt = cog_r;
    sog_nxt = sog_r;
    ts_nxt = TIME_STAMP_NA;
    sync_nxt = SYNC_NO_FIX;
    if (fix_valid) begin
      had_fix_nxt = 1'b1;
      lon_nxt = gnss_lon;
      lat_nxt = gnss_lat;
      cog_nxt = gnss_course_over_ground_field;
      sog_nxt = gnss_speed_over_ground_field;
      ts_nxt = utc_second;
      sync_nxt = SYNC_UTC_DIRECT;
    end else if (restart || !had_fix_r) begin
      // A new activation forgets any earlier fix
      had_fix_nxt = 1'b0;
      lon_nxt = LON_NA;
      lat_nxt = LAT_NA;
      cog_nxt = COG_NA;
      sog_nxt = SOG_NA;
    end
    // Otherwise position holds, time stamp 63, sync 3
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      had_fix_r <= 1'b0;
      lon_r <= LON_NA;
      lat_r <= LAT_NA;
      cog_r <= COG_NA;
      sog_r <= SOG_NA;
      ts_r <= TIME_STAMP_NA;
      sync_r <= SYNC_NO_FIX;
    end else if (clk_en) begin
      had_fix_r <= had_fix_nxt;
      lon_r <= lon_nxt;
      lat_r <= lat_nxt;
      cog_r <= cog_nxt;
      sog_r <= sog_nxt;
      ts_r <= ts_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pos_lon = lon_r;
  assign pos_lat = lat_r;
  assign pos_course_over_ground_field = cog_r;
  assign pos_speed_over_ground_field = sog_r;
  assign pos_time_stamp = ts_r;
  assign pos_sync_state = sync_r;

endmodule

/* File: mobls_scheduler.sv */
`timescale 1ns/1ps
module mobls_scheduler
  import mobls_pkg::*;
#(
  parameter int SLOTS_PER_MIN = SLOTS_PER_MIN_DEF,
  parameter int TEST_WAIT_SLOTS = TEST_WAIT_SLOTS_DEF,
  parameter logic START_CH = 1'b0,
  parameter logic [15:0] RAND_SEED = LFSR_SEED_DEF
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start_active,
  input wire logic start_test,
  input wire logic stop,
  input wire logic slot_tick,
  input wire logic [SUB_W-1:0] slot_number,
  input wire logic fix_valid,
  input wire logic [LON_W-1:0] gnss_lon,
  input wire logic [LAT_W-1:0] gnss_lat,
  input wire logic [COG_W-1:0] gnss_course_over_ground_field,
  input wire logic [SOG_W-1:0] gnss_speed_over_ground_field,
  input wire logic [5:0] utc_second,
  input wire logic [4:0] utc_hour,
  input wire logic [5:0] utc_minute,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic tx_channel,
  output logic [5:0] tx_msg_id,
  output logic tx_text_test,
  output logic [3:0] tx_nav_status,
  output logic [2:0] tx_time_out,
  output logic [SUB_W-1:0] tx_sub_message,
  output logic [LON_W-1:0] tx_lon,
  output logic [LAT_W-1:0] tx_lat,
  output logic [COG_W-1:0] tx_course_over_ground_field,
  output logic [SOG_W-1:0] tx_speed_over_ground_field,
  output logic [5:0] tx_time_stamp,
  output logic [1:0] tx_sync_state,
  output logic active_mode,
  output logic test_mode
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACT_WAIT, ST_ACT_SEND, ST_TEST_WAIT, ST_TEST_SEND
  } mobls_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Sub-message by cycle position; the odd last burst must be tested first
  function automatic mobls_sub_e sub_kind(input logic [2:0] burst);
    mobls_sub_e k;
    k = SUB_ZERO;
    if (burst == INCR_BURST) begin
      k = SUB_INCR;
    end else if (burst[0]) begin
      k = SUB_SLOT;
    end else if (burst == UTC_BURST) begin
      k = SUB_UTC;
    end
    return k;
  endfunction

  // Counter step on a slot tick, saturating so it never wraps
  function automatic logic [CNT_W-1:0] tick_inc(input logic [CNT_W-1:0] c);
    logic [CNT_W-1:0] r;
    r = c;
    if (c != {CNT_W{1'b1}}) begin
      r = c + 14'h0001;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  mobls_state_e state_r, state_nxt;
  logic [2:0] burst_r, burst_nxt;
  logic [2:0] msg_r, msg_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] interval_r, interval_nxt;
  logic [INCR_W-1:0] incr_r, incr_nxt;
  logic valid_r, valid_nxt;
  logic chan_r, chan_nxt;
  logic [5:0] id_r, id_nxt;
  logic text_test_r, text_test_nxt;
  logic [3:0] nav_r, nav_nxt;
  logic [2:0] to_r, to_nxt;
  logic [SUB_W-1:0] sub_r, sub_nxt;
  logic [LON_W-1:0] lon_r, lon_nxt;
  logic [LAT_W-1:0] lat_r, lat_nxt;
  logic [COG_W-1:0] cog_r, cog_nxt;
  logic [SOG_W-1:0] sog_r, sog_nxt;
  logic [5:0] ts_r, ts_nxt;
  logic [1:0] sync_r, sync_nxt;

  logic [INCR_W-1:0] rand_incr;
  logic [LON_W-1:0] pos_lon;
  logic [LAT_W-1:0] pos_lat;
  logic [COG_W-1:0] pos_cog;
  logic [SOG_W-1:0] pos_sog;
  logic [5:0] pos_ts;
  logic [1:0] pos_sync;
  logic restart;
  logic in_test;
  logic is_text;
  logic launch;
  logic taken;
  logic [CNT_W-1:0] cnt_step;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Any new activation drops the remembered fix
  assign restart = !stop && (start_active || start_test);

  mobls_rand_incr #(
    .SEED(RAND_SEED)
  ) u_rand (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .incr(rand_incr)
  );

  mobls_fix_hold u_fix (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(restart),
    .fix_valid(fix_valid),
    .gnss_lon(gnss_lon),
    .gnss_lat(gnss_lat),
    .gnss_course_over_ground_field(gnss_course_over_ground_field),
    .gnss_speed_over_ground_field(gnss_speed_over_ground_field),
    .utc_second(utc_second),
    .pos_lon(pos_lon),
    .pos_lat(pos_lat),
    .pos_course_over_ground_field(pos_cog),
    .pos_speed_over_ground_field(pos_sog),
    .pos_time_stamp(pos_ts),
    .pos_sync_state(pos_sync)
  );

  // Layout of the message about to be launched
  always_comb begin
    in_test = (state_r == ST_TEST_SEND);
    if (in_test) begin
      is_text = (msg_r == 3'h0) || (msg_r == LAST_MSG_IDX);
    end else begin
      is_text = ((burst_r == TEXT_BURST_A) || (burst_r == TEXT_BURST_B))
                && ((msg_r == TEXT_POS_A) || (msg_r == TEXT_POS_B));
    end
    taken = valid_r && tx_ready;
    // One message per slot, never overlapping one still waiting
    launch = !valid_r && slot_tick
             && ((state_r == ST_ACT_SEND) || in_test);
    cnt_step = slot_tick ? tick_inc(cnt_r) : cnt_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: mode, burst and message position, slot counting
  always_comb begin
    state_nxt = state_r;
    burst_nxt = burst_r;
    msg_nxt = msg_r;
    cnt_nxt = cnt_r;
    interval_nxt = interval_r;
    incr_nxt = incr_r;
    valid_nxt = valid_r;
    if (stop) begin
      // Stop wins over a simultaneous activation
      state_nxt = ST_IDLE;
      valid_nxt = 1'b0;
    end else if (start_active) begin
      state_nxt = ST_ACT_SEND;
      burst_nxt = 3'h0;
      msg_nxt = 3'h0;
      cnt_nxt = '0;
      valid_nxt = 1'b0;
    end else if (start_test) begin
      state_nxt = ST_TEST_WAIT;
      msg_nxt = 3'h0;
      cnt_nxt = '0;
      valid_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_ACT_WAIT: begin
          cnt_nxt = cnt_step;
          if (cnt_step >= interval_r) begin
            state_nxt = ST_ACT_SEND;
            cnt_nxt = '0;
            msg_nxt = 3'h0;
          end
        end
        ST_ACT_SEND, ST_TEST_SEND: begin
          // Interval runs from the start of the burst
          cnt_nxt = cnt_step;
          if (launch) begin
            valid_nxt = 1'b1;
          end else if (taken) begin
            valid_nxt = 1'b0;
            msg_nxt = msg_r + 3'h1;
            if (msg_r == LAST_MSG_IDX) begin
              if (in_test) begin
                state_nxt = ST_IDLE;
              end else begin
                state_nxt = ST_ACT_WAIT;
                burst_nxt = burst_r + 3'h1;
                interval_nxt = CNT_W'(SLOTS_PER_MIN);
                if (burst_r == INCR_BURST) begin
                  // Announced increment sets the next gap
                  interval_nxt = CNT_W'(incr_r);
                end
                if (burst_r == INCR_BURST - 3'h1) begin
                  incr_nxt = rand_incr;
                end
              end
            end
          end
        end
        ST_TEST_WAIT: begin
          cnt_nxt = cnt_step;
          if (fix_valid) begin
            state_nxt = ST_TEST_SEND;
          end else if (cnt_step >= CNT_W'(TEST_WAIT_SLOTS)) begin
            state_nxt = ST_TEST_SEND;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      burst_r <= 3'h0;
      msg_r <= 3'h0;
      cnt_r <= '0;
      interval_r <= CNT_W'(SLOTS_PER_MIN);
      incr_r <= INCR_W'(INCR_MIN);
      valid_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      burst_r <= burst_nxt;
      msg_r <= msg_nxt;
      cnt_r <= cnt_nxt;
      interval_r <= interval_nxt;
      incr_r <= incr_nxt;
      valid_r <= valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message fields, captured at launch and held until taken
  always_comb begin
    chan_nxt = chan_r;
    id_nxt = id_r;
    text_test_nxt = text_test_r;
    nav_nxt = nav_r;
    to_nxt = to_r;
    sub_nxt = sub_r;
    lon_nxt = lon_r;
    lat_nxt = lat_r;
    cog_nxt = cog_r;
    sog_nxt = sog_r;
    ts_nxt = ts_r;
    sync_nxt = sync_r;
    if (launch && !stop && !start_active && !start_test) begin
      chan_nxt = START_CH ^ msg_r[0];
      id_nxt = is_text ? MSG_SAFETY_TEXT : MSG_POS_REPORT;
      text_test_nxt = in_test;
      nav_nxt = in_test ? NAV_TEST : NAV_ACTIVE;
      // Time-out counts down 7..0 over the cycle, pre-announcing slots
      to_nxt = in_test ? TIME_OUT_TEST : TIME_OUT_FIRST - burst_r;
      sub_nxt = '0;
      if (!in_test) begin
        case (sub_kind(burst_r))
          SUB_SLOT: sub_nxt = slot_number;
          SUB_UTC: sub_nxt = {utc_hour, 1'b0, utc_minute, 2'h0};
          SUB_INCR: sub_nxt = {2'h0, incr_r};
          default: sub_nxt = '0;
        endcase
      end
      lon_nxt = pos_lon;
      lat_nxt = pos_lat;
      cog_nxt = pos_cog;
      sog_nxt = pos_sog;
      ts_nxt = pos_ts;
      sync_nxt = pos_sync;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_r <= 1'b0;
      id_r <= MSG_POS_REPORT;
      text_test_r <= 1'b0;
      nav_r <= NAV_ACTIVE;
      to_r <= TIME_OUT_FIRST;
      sub_r <= '0;
      lon_r <= LON_NA;
      lat_r <= LAT_NA;
      cog_r <= COG_NA;
      sog_r <= SOG_NA;
      ts_r <= TIME_STAMP_NA;
      sync_r <= SYNC_NO_FIX;
    end else if (clk_en) begin
      chan_r <= chan_nxt;
      id_r <= id_nxt;
      text_test_r <= text_test_nxt;
      nav_r <= nav_nxt;
      to_r <= to_nxt;
      sub_r <= sub_nxt;
      lon_r <= lon_nxt;
      lat_r <= lat_nxt;
      cog_r <= cog_nxt;
      sog_r <= sog_nxt;
      ts_r <= ts_nxt;
      sync_r <= sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign tx_valid = valid_r;
  assign tx_channel = chan_r;
  assign tx_msg_id = id_r;
  assign tx_text_test = text_test_r;
  assign tx_nav_status = nav_r;
  assign tx_time_out = to_r;
  assign tx_sub_message = sub_r;
  assign tx_lon = lon_r;
  assign tx_lat = lat_r;
  assign tx_course_over_ground_field = cog_r;
  assign tx_speed_over_ground_field = sog_r;
  assign tx_time_stamp = ts_r;
  assign tx_sync_state = sync_r;
  assign active_mode = (state_r == ST_ACT_WAIT) || (state_r == ST_ACT_SEND);
  assign test_mode = (state_r == ST_TEST_WAIT) || in_test;

endmodule

/* File: mobls_chk.sv */
`timescale 1ns/1ps
module mobls_chk
  import mobls_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_active,
  input wire logic start_test,
  input wire logic stop,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic tx_channel,
  input wire logic [5:0] tx_msg_id,
  input wire logic tx_text_test,
  input wire logic [3:0] tx_nav_status,
  input wire logic [2:0] tx_time_out,
  input wire logic [SUB_W-1:0] tx_sub_message,
  input wire logic [5:0] tx_time_stamp,
  input wire logic [1:0] tx_sync_state,
  input wire logic active_mode,
  input wire logic test_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic last_ch_r, last_ch_nxt, seen_r, seen_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Channel of the last taken message; any start or stop pulse forgets it
  always_comb begin
    last_ch_nxt = last_ch_r;
    seen_nxt = seen_r;
    if (tx_valid && tx_ready) begin
      last_ch_nxt = tx_channel;
      seen_nxt = 1'b1;
    end
    if (start_active || start_test || stop) begin
      seen_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ch_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      last_ch_r <= last_ch_nxt;
      seen_r <= seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_nav_active;
    active_mode && tx_valid && tx_msg_id == MSG_POS_REPORT
      |-> tx_nav_status == NAV_ACTIVE;
  endproperty
  a_nav_active: assert property (p_nav_active)
    else $error("active report with wrong nav status");

  property p_test_fields;
    test_mode && tx_valid && tx_msg_id == MSG_POS_REPORT |->
      tx_nav_status == NAV_TEST && tx_time_out == 3'h0 && tx_sub_message == 0;
  endproperty
  a_test_fields: assert property (p_test_fields)
    else $error("test report fields wrong");

  property p_test_text;
    test_mode && tx_valid |-> tx_text_test;
  endproperty
  a_test_text: assert property (p_test_text)
    else $error("test burst message not marked as test");

  property p_alternate;
    $rose(tx_valid) && seen_r |-> tx_channel != last_ch_r;
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("channel did not alternate");

  property p_stamp_fix;
    tx_valid && tx_sync_state == SYNC_UTC_DIRECT |-> tx_time_stamp <= 6'h3b;
  endproperty
  a_stamp_fix: assert property (p_stamp_fix)
    else $error("time stamp out of range with fix");

  property p_stamp_nofix;
    tx_valid && tx_sync_state == SYNC_NO_FIX |-> tx_time_stamp == TIME_STAMP_NA;
  endproperty
  a_stamp_nofix: assert property (p_stamp_nofix)
    else $error("time stamp not 63 without fix");

  property p_incr;
    active_mode && tx_valid && tx_msg_id == MSG_POS_REPORT &&
      tx_time_out == 3'h0 |-> tx_sub_message inside {[14'h7e9:14'h9ab]};
  endproperty
  a_incr: assert property (p_incr)
    else $error("slot increment out of range");

  property p_hold;
    tx_valid && !tx_ready && !stop && !start_active && !start_test |=>
      tx_valid && $stable(tx_sub_message) && $stable(tx_time_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("comm state changed while pending");
endmodule

bind mobls_scheduler mobls_chk u_chk (.clk, .rst_n, .start_active,
  .start_test, .stop, .tx_ready, .tx_valid, .tx_channel, .tx_msg_id,
  .tx_text_test, .tx_nav_status, .tx_time_out, .tx_sub_message,
  .tx_time_stamp, .tx_sync_state, .active_mode, .test_mode);

/* File: mobls_rx_model.sv */
`timescale 1ns/1ps
module mobls_rx_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [1:0] wait_r;

  // Receiver accepts after a two-cycle stall in slow mode, still before the next tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      wait_r <= 2'h0;
    end else if (tx_valid && !tx_ready) begin
      wait_r <= wait_r + 2'h1;
      tx_ready <= !slow || wait_r == 2'h1;
    end else begin
      wait_r <= 2'h0;
      tx_ready <= 1'b0;
    end
  end
endmodule

/* File: mob_locator_burst_scheduler_test.sv */
`timescale 1ns/1ps
module mob_locator_burst_scheduler_test
  import mobls_pkg::*;
;
  typedef struct {
    logic ch; logic [5:0] id; logic tt; logic [1:0] kind; logic [3:0] nav;
    logic [2:0] to; logic [SUB_W-1:0] sub; logic [LON_W-1:0] lon;
    logic [LAT_W-1:0] lat; logic [COG_W-1:0] course_over_ground_field; logic [SOG_W-1:0] speed_over_ground_field;
    logic [5:0] ts; logic [1:0] sy;
  } mobls_exp_s;

  logic clk = 1'b0;
  logic rst_n, start_active, start_test, stop, slot_tick, fix_valid, slow;
  logic tx_ready, tx_valid, tx_channel, tx_text_test, active_mode, test_mode;
  logic [SUB_W-1:0] slot_number, tx_sub_message;
  logic [LON_W-1:0] gnss_lon, tx_lon, e_lon;
  logic [LAT_W-1:0] gnss_lat, tx_lat, e_lat;
  logic [COG_W-1:0] gnss_cog, tx_cog, e_cog;
  logic [SOG_W-1:0] gnss_sog, tx_sog, e_sog;
  logic [5:0] utc_second, utc_minute, tx_msg_id, tx_time_stamp, e_ts;
  logic [4:0] utc_hour;
  logic [3:0] tx_nav_status;
  logic [2:0] tx_time_out;
  logic [1:0] tx_sync_state, e_sy, tdiv;
  logic [31:0] rs;
  mobls_exp_s q[$];
  mobls_exp_s e;
  int fails, total_checks, seen, n;

  always #20 clk = ~clk;

  mobls_scheduler #(.SLOTS_PER_MIN(20), .TEST_WAIT_SLOTS(30)) u_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .start_active(start_active),
    .start_test(start_test), .stop(stop), .slot_tick(slot_tick),
    .slot_number(slot_number), .fix_valid(fix_valid), .gnss_lon(gnss_lon),
    .gnss_lat(gnss_lat), .gnss_course_over_ground_field(gnss_cog),
    .gnss_speed_over_ground_field(gnss_sog), .utc_second(utc_second),
    .utc_hour(utc_hour), .utc_minute(utc_minute), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_channel(tx_channel), .tx_msg_id(tx_msg_id),
    .tx_text_test(tx_text_test), .tx_nav_status(tx_nav_status),
    .tx_time_out(tx_time_out), .tx_sub_message(tx_sub_message),
    .tx_lon(tx_lon), .tx_lat(tx_lat), .tx_course_over_ground_field(tx_cog),
    .tx_speed_over_ground_field(tx_sog), .tx_time_stamp(tx_time_stamp),
    .tx_sync_state(tx_sync_state), .active_mode(active_mode),
    .test_mode(test_mode));

  mobls_rx_model u_rx (.clk(clk), .rst_n(rst_n), .slow(slow),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    total_checks++;
    if (sv !== ev) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, ev, sv);
    end
  endtask

  task pulse(input int w);
    @(posedge clk);
    if (w == 0) start_active <= 1'b1;
    else if (w == 1) start_test <= 1'b1;
    else stop <= 1'b1;
    @(posedge clk);
    start_active <= 1'b0;
    start_test <= 1'b0;
    stop <= 1'b0;
  endtask

  // Mode 0 live fix, 1 fix lost (old values held), 2 never fixed
  task set_fix(input int m);
    if (m == 1) {e_lon, e_lat, e_cog, e_sog} = {gnss_lon, gnss_lat, gnss_cog,
      gnss_sog};
    @(posedge clk);
    fix_valid <= (m == 0);
    {gnss_lon, gnss_lat} <= 55'({xs(), xs()});
    {gnss_cog, gnss_sog} <= 22'(xs());
    utc_second <= 6'(xs() % 60);
    @(posedge clk);
    if (m == 0) {e_lon, e_lat, e_cog, e_sog, e_ts, e_sy} = {gnss_lon,
      gnss_lat, gnss_cog, gnss_sog, utc_second, SYNC_UTC_DIRECT};
    else {e_ts, e_sy} = {TIME_STAMP_NA, SYNC_NO_FIX};
    if (m == 2) {e_lon, e_lat, e_cog, e_sog} = {LON_NA, LAT_NA, COG_NA, SOG_NA};
  endtask

  // Notes the eight expected messages of burst index b
  task push(input int b, input logic t);
    mobls_exp_s x;
    for (int i = 0; i < MSGS_PER_BURST; i++) begin
      x.kind = t ? 2'((i == 0) || (i == 7)) :
        2'(((b == 0) || (b == 4)) && ((i == 4) || (i == 5)));
      if (!t && b == 7) x.kind = 2'h2;
      x.ch = 1'(i);
      x.id = (x.kind == 2'h1) ? MSG_SAFETY_TEXT : MSG_POS_REPORT;
      x.tt = t;
      x.nav = t ? NAV_TEST : NAV_ACTIVE;
      x.to = t ? 3'h0 : 3'(7 - b);
      x.sub = (t || b % 2 == 0) ? '0 : slot_number;
      if (!t && b == 6) x.sub = {utc_hour, 1'b0, utc_minute, 2'b00};
      {x.lon, x.lat, x.course_over_ground_field, x.speed_over_ground_field, x.ts, x.sy} = {e_lon, e_lat, e_cog,
        e_sog, e_ts, e_sy};
      q.push_back(x);
    end
  endtask

  task wait_msgs(input int k);
    int tgt;
    tgt = seen + k;
    for (int j = 0; j < 12000 && seen < tgt; j++) @(posedge clk);
    if (seen < tgt) begin
      check("message count", seen, tgt);
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Slot ticks every fourth cycle, room for a take between launches
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    slot_tick <= (tdiv == 2'h2);
  end

  // Each taken message is compared with the oldest note
  always @(posedge clk) begin
    if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      seen++;
      if (q.size() == 0) check("surplus message", 1, 0);
      else begin
        e = q.pop_front();
        check("channel", tx_channel, e.ch);
        check("msg_id", tx_msg_id, e.id);
        check("text_test", tx_text_test, e.tt);
        check("mode", {active_mode, test_mode}, {!e.tt, e.tt});
        if (e.kind != 2'h1) begin
          check("nav", tx_nav_status, e.nav);
          check("time_out", tx_time_out, e.to);
          if (e.kind == 2'h2) check("incr", tx_sub_message >= 14'h7e9 &&
            tx_sub_message <= 14'h9ab, 1);
          else check("sub", tx_sub_message, e.sub);
          check("lon", tx_lon, e.lon);
          check("lat", tx_lat, e.lat);
          check("cog_sog", {tx_cog, tx_sog}, {e.course_over_ground_field, e.speed_over_ground_field});
          check("stamp", {tx_time_stamp, tx_sync_state}, {e.ts, e.sy});
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, start_active, start_test, stop, fix_valid, slow} = '0;
    {tdiv, slot_tick, gnss_lon, gnss_lat, gnss_cog, gnss_sog} = '0;
    {utc_second, utc_hour, utc_minute, slot_number} = '0;
    {e_lon, e_lat, e_cog, e_sog, e_ts, e_sy} = '0;
    {fails, total_checks, seen} = '0;
    rs = 32'h55;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    slot_number <= SUB_W'(xs());
    utc_hour <= 5'(xs() % 24);
    utc_minute <= 6'(xs() % 60);
    // Ten bursts: wraps past burst 8, fix lost from burst 4 on
    set_fix(0);
    for (int b = 0; b < 10; b++) begin
      if (b == 3) set_fix(1);
      push(b % 8, 1'b0);
      if (b == 0) pulse(0);
      wait_msgs(8);
    end
    pulse(2);
    $display("test active_cycle done");
    // Test burst with fix and a stalling receiver, then silence
    slow <= 1'b1;
    set_fix(0);
    push(0, 1'b1);
    pulse(1);
    wait_msgs(8);
    repeat (160) @(posedge clk);
    check("test_mode", test_mode, 0);
    $display("test single_test_burst done");
    // Test without fix: quiet for the whole wait, then defaults
    slow <= 1'b0;
    set_fix(2);
    push(0, 1'b1);
    pulse(1);
    for (n = 0; n < 400 && tx_valid !== 1'b1; n++) @(posedge clk);
    check("quiet", n >= 120 && n < 400, 1);
    if (n >= 400) print_verdict();
    wait_msgs(8);
    $display("test no_fix_test done");
    // Reactivation from idle after the test burst restarts at the first burst, no fix known
    push(0, 1'b0);
    pulse(0);
    wait_msgs(8);
    pulse(2);
    $display("test reactivate done");
    print_verdict();
  end
endmodule
